//--- inc/pmsi_regs.svh
// Register offsets, field positions, codes and reset values of the status register bank.
`ifndef PMSI_REGS_SVH
`define PMSI_REGS_SVH

`define PMSI_OFF_CHIP_ID 8'h00
`define PMSI_OFF_SILICON_REVISION 8'h01
`define PMSI_OFF_THERMAL_CHARGE_STATE 8'h02
`define PMSI_OFF_INPUT_CHARGER_FLAGS 8'h03
`define PMSI_OFF_REGULATOR_THERMAL_FLAGS 8'h04
`define PMSI_OFF_CHANGE_EVENTS_A 8'h05
`define PMSI_OFF_CHANGE_EVENTS_B 8'h06
`define PMSI_OFF_EVENT_MASK_A 8'h07
`define PMSI_OFF_EVENT_MASK_B 8'h08

`define PMSI_ZONE_LSB 3
`define PMSI_ZONE_MSB 5
`define PMSI_CHG_LSB 0
`define PMSI_CHG_MSB 2
`define PMSI_LIMIT_BIT 5
`define PMSI_OVP_BIT 4
`define PMSI_VALID_BIT 3
`define PMSI_SHDN_BIT 2
`define PMSI_TREG_BIT 1
`define PMSI_TMO_BIT 0

`define PMSI_ZONE_MAX 3'h4
`define PMSI_ZONE_ABSENT 3'h5
`define PMSI_ZONE_DISABLED 3'h6
`define PMSI_CHG_FAULT 3'h7

`define PMSI_MASK_A_RESET 8'h00
`define PMSI_MASK_B_RESET 8'h00
`define PMSI_REG_COUNT 5

`endif

//--- inc/pmsi_pkg.sv
// Types shared by the status register bank.
package pmsi_pkg;
  typedef logic [7:0] pmsi_byte_type;
  typedef logic [2:0] pmsi_code_type;
endpackage

//--- hw/pmsi_change_det.sv
// Per-bit change detector that turns a level difference into a one-cycle pulse.
`timescale 1ns/10ps
module pmsi_change_det #(
  parameter int WIDTH = 17
) (
  input wire logic clk_sys_i,
  input wire logic reset_n_i,
  input wire logic [WIDTH-1:0] level_i,
  output logic [WIDTH-1:0] change_o
);
  logic [WIDTH-1:0] prev_r;

  // A bit already high at reset release reports once, like a first detection.
  genvar g;
  generate
    for (g = 0; g < WIDTH; g++) begin : g_bit
      always_ff @(posedge clk_sys_i) begin
        if (!reset_n_i) begin
          prev_r[g] <= 1'b0;
        end else begin
          prev_r[g] <= level_i[g];
        end
      end
      assign change_o[g] = level_i[g] ^ prev_r[g];
    end
  endgenerate
endmodule // pmsi_change_det

//--- hw/pmsi_status_regs.sv
// Status and clear-on-read event registers of the charger power-management device.
`timescale 1ns/10ps
`include "pmsi_regs.svh"

// Summary of operation
// - Temperature zone code, absent 101, disabled 110.
// - Current-limit status bit five while limiting.
// - Five regulator thermal-off bits, low bits.
// - Status change sets matching event bit.
// - Mask zero blocks event, one passes it.
// - Off state restores writable registers' defaults.
module pmsi_status_regs import pmsi_pkg::*; #(
  parameter pmsi_byte_type CHIP_ID = 8'h5A, // Arbitrary value.
  parameter pmsi_byte_type SILICON_REVISION = 8'h11 // Arbitrary value.
) (
  input wire logic clk_sys_i,
  input wire logic reset_n_i,
  input wire logic off_state_i,
  input wire logic thermistor_input_enable_i,
  input wire logic thermistor_detected_i,
  input wire logic [2:0] zone_index_i,
  input wire logic [2:0] charger_state_i,
  input wire logic input_current_limited_i,
  input wire logic input_overvoltage_i,
  input wire logic input_voltage_valid_i,
  input wire logic charger_thermal_shutdown_i,
  input wire logic charger_thermal_regulation_i,
  input wire logic charger_timeout_i,
  input wire logic [4:0] regulator_thermal_off_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic reg_rd_i,
  input wire logic reg_wr_i,
  input wire logic [7:0] reg_wdata_i,
  output logic [7:0] reg_rdata_o,
  output logic reg_rvalid_o,
  output logic irq_o
);

  // **********************************************************************
  // Live status capture
  // **********************************************************************
  pmsi_byte_type thermal_charge_state_r;
  pmsi_byte_type input_charger_flags_r;
  pmsi_byte_type regulator_thermal_flags_r;
  pmsi_code_type zone_nxt;
  pmsi_code_type charger_nxt;

  always_comb begin
    if (!thermistor_input_enable_i) begin
      zone_nxt = `PMSI_ZONE_DISABLED;
    end else if (!thermistor_detected_i) begin
      zone_nxt = `PMSI_ZONE_ABSENT;
    end else if (zone_index_i > `PMSI_ZONE_MAX) begin
      zone_nxt = `PMSI_ZONE_MAX;
    end else begin
      zone_nxt = zone_index_i;
    end
  end

  // A timeout overrides whatever the charger reports, so software sees one fault code.
  assign charger_nxt = charger_timeout_i ? `PMSI_CHG_FAULT : charger_state_i;

  always_ff @(posedge clk_sys_i) begin
    if (!reset_n_i) begin
      thermal_charge_state_r <= 8'h00;
    end else begin
      thermal_charge_state_r <= {2'b00, zone_nxt, charger_nxt};
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!reset_n_i) begin
      input_charger_flags_r <= 8'h00;
    end else begin
      input_charger_flags_r <= {2'b00,
                                input_current_limited_i,
                                input_overvoltage_i,
                                input_voltage_valid_i,
                                charger_thermal_shutdown_i,
                                charger_thermal_regulation_i,
                                charger_timeout_i};
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!reset_n_i) begin
      regulator_thermal_flags_r <= 8'h00;
    end else begin
      regulator_thermal_flags_r <= {3'b000, regulator_thermal_off_i};
    end
  end

  // **********************************************************************
  // Change events
  // **********************************************************************
  logic [16:0] change;
  pmsi_byte_type event_a;
  pmsi_byte_type event_b;
  pmsi_byte_type change_events_a_r;
  pmsi_byte_type change_events_b_r;
  logic read_a;
  logic read_b;

  pmsi_change_det #(.WIDTH(17)) u_change (
    .clk_sys_i(clk_sys_i),
    .reset_n_i(reset_n_i),
    .level_i({regulator_thermal_flags_r[4:0], input_charger_flags_r[5:0],
              thermal_charge_state_r[5:0]}),
    .change_o(change)
  );

  assign event_a = {|change[5:3], |change[2:0], change[11:6]};
  assign event_b = {3'b000, change[16:12]};
  assign read_a = reg_rd_i && (reg_addr_i == `PMSI_OFF_CHANGE_EVENTS_A);
  assign read_b = reg_rd_i && (reg_addr_i == `PMSI_OFF_CHANGE_EVENTS_B);

  // A new event in the cycle of the clearing read survives, so none is lost.
  always_ff @(posedge clk_sys_i) begin
    if (!reset_n_i) begin
      change_events_a_r <= 8'h00;
    end else begin
      change_events_a_r <= (read_a ? 8'h00 : change_events_a_r) | event_a;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!reset_n_i) begin
      change_events_b_r <= 8'h00;
    end else begin
      change_events_b_r <= (read_b ? 8'h00 : change_events_b_r) | event_b;
    end
  end

  // **********************************************************************
  // Masks and interrupt output
  // **********************************************************************
  pmsi_byte_type event_mask_a_r;
  pmsi_byte_type event_mask_b_r;

  always_ff @(posedge clk_sys_i) begin
    if (!reset_n_i || off_state_i) begin
      event_mask_a_r <= `PMSI_MASK_A_RESET;
      event_mask_b_r <= `PMSI_MASK_B_RESET;
    end else if (reg_wr_i && reg_addr_i == `PMSI_OFF_EVENT_MASK_A) begin
      event_mask_a_r <= reg_wdata_i;
    end else if (reg_wr_i && reg_addr_i == `PMSI_OFF_EVENT_MASK_B) begin
      event_mask_b_r <= {3'b000, reg_wdata_i[4:0]};
    end
  end

  // The line stays up until a clearing read; it is a level, not a pulse.
  assign irq_o = |(change_events_a_r & event_mask_a_r) |
                 |(change_events_b_r & event_mask_b_r);

  // **********************************************************************
  // Register read port
  // **********************************************************************
  pmsi_byte_type rdata_nxt;

  always_comb begin
    case (reg_addr_i)
      `PMSI_OFF_CHIP_ID: rdata_nxt = CHIP_ID;
      `PMSI_OFF_SILICON_REVISION: rdata_nxt = SILICON_REVISION;
      `PMSI_OFF_THERMAL_CHARGE_STATE: rdata_nxt = thermal_charge_state_r;
      `PMSI_OFF_INPUT_CHARGER_FLAGS: rdata_nxt = input_charger_flags_r;
      `PMSI_OFF_REGULATOR_THERMAL_FLAGS: rdata_nxt = regulator_thermal_flags_r;
      `PMSI_OFF_CHANGE_EVENTS_A: rdata_nxt = change_events_a_r;
      `PMSI_OFF_CHANGE_EVENTS_B: rdata_nxt = change_events_b_r;
      `PMSI_OFF_EVENT_MASK_A: rdata_nxt = event_mask_a_r;
      `PMSI_OFF_EVENT_MASK_B: rdata_nxt = event_mask_b_r;
      default: rdata_nxt = 8'h00;
    endcase
  end

  always_ff @(posedge clk_sys_i) begin
    if (!reset_n_i) begin
      reg_rdata_o <= 8'h00;
      reg_rvalid_o <= 1'b0;
    end else begin
      reg_rdata_o <= reg_rd_i ? rdata_nxt : reg_rdata_o;
      reg_rvalid_o <= reg_rd_i;
    end
  end

  // **********************************************************************
  // Assertions
  // **********************************************************************
  sequence read_a_s;
    reg_rd_i && reg_addr_i == `PMSI_OFF_CHANGE_EVENTS_A && event_a == 8'h00;
  endsequence

  sequence events_cleared_s;
    change_events_a_r == 8'h00;
  endsequence

  zone_disabled_a: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
    !thermistor_input_enable_i |=> thermal_charge_state_r[5:3] == 3'h6)
    else $error("zone code not 110 while thermistor input disabled");

  zone_absent_a: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
    thermistor_input_enable_i && !thermistor_detected_i
      |=> thermal_charge_state_r[5:3] == 3'h5)
    else $error("zone code not 101 with no thermistor");

  limit_flag_a: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
    ##1 input_charger_flags_r[5] == $past(input_current_limited_i))
    else $error("current-limit bit does not follow the limiter");

  timeout_fault_a: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
    charger_timeout_i |=> input_charger_flags_r[0] && thermal_charge_state_r[2:0] == 3'h7)
    else $error("timeout did not force fault code");

  reg_thermal_a: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
    ##1 regulator_thermal_flags_r == {3'b000, $past(regulator_thermal_off_i)})
    else $error("regulator thermal-off bits wrong");

  ovp_event_a: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
    ##1 $changed(input_charger_flags_r[4]) |=> change_events_a_r[4])
    else $error("overvoltage change did not set its event bit");

  read_clear_a: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
    read_a_s |=> events_cleared_s)
    else $error("event register not cleared by read");

  irq_gate_a: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
    event_mask_a_r == 8'h00 && event_mask_b_r == 8'h00 |-> !irq_o)
    else $error("interrupt raised with all events masked");

  off_default_a: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
    off_state_i |=> event_mask_a_r == 8'h00 && event_mask_b_r == 8'h00)
    else $error("masks not back to default after off state");

endmodule // pmsi_status_regs

//--- bench/pmsi_host_model.sv
// Host-side model that issues single register reads and writes.
`timescale 1ns/10ps
module pmsi_host_model (
  input wire logic clk_sys_i,
  input wire logic [7:0] rdata_i,
  input wire logic rvalid_i,
  output logic [7:0] addr_o,
  output logic rd_o,
  output logic wr_o,
  output logic [7:0] wdata_o
);
  // ********
  // Bus cycles
  // ********
  initial begin
    addr_o = 8'h00;
    rd_o = 1'b0;
    wr_o = 1'b0;
    wdata_o = 8'h00;
  end
  // Address and data are left as they were; only the strobe qualifies them.
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    addr_o <= a;
    wdata_o <= d;
    wr_o <= 1'b1;
    @(posedge clk_sys_i);
    wr_o <= 1'b0;
    // One idle edge keeps back-to-back writes from touching the strobe twice at once.
    @(posedge clk_sys_i);
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d, output bit ok);
    ok = 1'b0;
    d = 8'h00;
    addr_o <= a;
    rd_o <= 1'b1;
    @(posedge clk_sys_i);
    rd_o <= 1'b0;
    for (int n = 0; n < 4 && !ok; n++) begin
      @(posedge clk_sys_i);
      if (rvalid_i === 1'b1) begin
        ok = 1'b1;
        d = rdata_i;
      end
    end
  endtask
endmodule // pmsi_host_model

//--- bench/pmsi_status_regs_tb.sv
// Self-checking testbench of the status and event register bank.
`timescale 1ns/10ps
module pmsi_status_regs_tb;
  import pmsi_pkg::*;
  logic clk_sys_i, reset_n_i, off_state_i, thermistor_input_enable_i, thermistor_detected_i;
  logic input_current_limited_i, input_overvoltage_i, input_voltage_valid_i;
  logic charger_thermal_shutdown_i, charger_thermal_regulation_i, charger_timeout_i;
  logic [2:0] zone_index_i, charger_state_i;
  logic [4:0] regulator_thermal_off_i;
  logic [7:0] reg_addr_i, reg_wdata_i, reg_rdata_o;
  logic reg_rd_i, reg_wr_i, reg_rvalid_o, irq_o;
  int error_cnt = 0;
  int cmp_count = 0;
  pmsi_status_regs pmsi_status_regs_inst (.clk_sys_i, .reset_n_i, .off_state_i,
    .thermistor_input_enable_i, .thermistor_detected_i, .zone_index_i, .charger_state_i,
    .input_current_limited_i, .input_overvoltage_i, .input_voltage_valid_i,
    .charger_thermal_shutdown_i, .charger_thermal_regulation_i, .charger_timeout_i,
    .regulator_thermal_off_i, .reg_addr_i, .reg_rd_i, .reg_wr_i, .reg_wdata_i,
    .reg_rdata_o, .reg_rvalid_o, .irq_o);
  pmsi_host_model pmsi_host_model_inst (.clk_sys_i, .rdata_i(reg_rdata_o),
    .rvalid_i(reg_rvalid_o), .addr_o(reg_addr_i), .rd_o(reg_rd_i), .wr_o(reg_wr_i),
    .wdata_o(reg_wdata_i));
  // ********
  // Shared tasks
  // ********
  task automatic close_out();
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input pmsi_byte_type e, input pmsi_byte_type g);
    cmp_count++;
    if (g !== e) begin
      error_cnt++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys_i);
  endtask
  task automatic rc(input pmsi_byte_type a, input pmsi_byte_type e);
    pmsi_byte_type d;
    bit ok;
    pmsi_host_model_inst.rd(a, d, ok);
    if (!ok) begin
      error_cnt++;
      $display("BAD rvalid expected 1 seen 0");
      close_out();
    end else begin
      chk($sformatf("reg %h", a), e, d);
    end
  endtask
  task automatic wr(input pmsi_byte_type a, input pmsi_byte_type d);
    pmsi_host_model_inst.wr(a, d);
  endtask
  // ********
  // Scenarios
  // ********
  task automatic t_map();
    wr(8'h01, 8'hFF);
    rc(8'h01, 8'h11);
    rc(8'h30, 8'h00);
  endtask
  task automatic t_zone();
    charger_state_i <= 3'h3;
    thermistor_input_enable_i <= 1'b0;
    tick(2);
    rc(8'h02, 8'h33);
    thermistor_input_enable_i <= 1'b1;
    thermistor_detected_i <= 1'b0;
    tick(2);
    rc(8'h02, 8'h2B);
    thermistor_detected_i <= 1'b1;
    for (int i = 0; i < 5; i++) begin
      zone_index_i <= 3'(i);
      tick(2);
      rc(8'h02, 8'(i * 8 + 3));
    end
    zone_index_i <= 3'h7;
    tick(2);
    rc(8'h02, 8'h23);
  endtask
  task automatic t_flags();
    input_current_limited_i <= 1'b1;
    charger_timeout_i <= 1'b1;
    tick(2);
    rc(8'h03, 8'h21);
    rc(8'h02, 8'h27);
    input_current_limited_i <= 1'b0;
    charger_timeout_i <= 1'b0;
    tick(2);
    rc(8'h03, 8'h00);
  endtask
  task automatic t_regs();
    for (int i = 0; i < 5; i++) begin
      regulator_thermal_off_i <= 5'(1 << i);
      tick(2);
      rc(8'h04, 8'(1 << i));
    end
    regulator_thermal_off_i <= 5'h00;
    tick(3);
    rc(8'h06, 8'h1F);
    rc(8'h06, 8'h00);
  endtask
  task automatic t_events();
    rc(8'h05, 8'hE1);
    wr(8'h07, 8'h10);
    input_overvoltage_i <= 1'b1;
    tick(3);
    chk("irq", 8'h01, {7'h00, irq_o});
    rc(8'h05, 8'h10);
    chk("irq", 8'h00, {7'h00, irq_o});
    rc(8'h05, 8'h00);
    wr(8'h07, 8'h00);
    input_voltage_valid_i <= 1'b1;
    charger_thermal_shutdown_i <= 1'b1;
    charger_thermal_regulation_i <= 1'b1;
    tick(3);
    chk("irq", 8'h00, {7'h00, irq_o});
    rc(8'h03, 8'h1E);
    rc(8'h05, 8'h0E);
  endtask
  task automatic t_off();
    wr(8'h07, 8'hA5);
    wr(8'h08, 8'h1F);
    rc(8'h08, 8'h1F);
    off_state_i <= 1'b1;
    tick(2);
    off_state_i <= 1'b0;
    tick(1);
    rc(8'h07, 8'h00);
    rc(8'h08, 8'h00);
  endtask
  // ********
  // Main sequence
  // ********
  initial begin
    clk_sys_i = 1'b0;
    forever #5 clk_sys_i = ~clk_sys_i;
  end
  initial begin
    reset_n_i = 1'b0;
    off_state_i = 1'b0;
    thermistor_input_enable_i = 1'b1;
    thermistor_detected_i = 1'b1;
    zone_index_i = 3'h0;
    charger_state_i = 3'h0;
    input_current_limited_i = 1'b0;
    input_overvoltage_i = 1'b0;
    input_voltage_valid_i = 1'b0;
    charger_thermal_shutdown_i = 1'b0;
    charger_thermal_regulation_i = 1'b0;
    charger_timeout_i = 1'b0;
    regulator_thermal_off_i = 5'h00;
    tick(4);
    reset_n_i <= 1'b1;
    t_map();
    t_zone();
    t_flags();
    t_regs();
    t_events();
    t_off();
    close_out();
  end
endmodule // pmsi_status_regs_tb
